//--- core/counter_osc_pkg.sv
/*
 * Constants, register map and state carriers of the 16-bit counter with its own
 * low-power crystal oscillator, sleep counting and overflow wake-up.
 * Assumes one system clock of 200 MHz, which stands for the oscillator clock Fosc.
 */
// What this block does
// - Oscillator enable bit starts and stops oscillator.
// - Crystal oscillator keeps running during sleep.
// - Oscillator usable only with internal system clock.
// - Oscillator on forces shared pins input, reads.
// - Sleep counting only in asynchronous external mode.
// - Overflow wakes device; global enable adds branch.
// - Count reachable as low and high bytes.
// - Sync disable lets external count run asynchronously.
// - Source select: external rising edge, or Fosc/4.
// - Prescale select divides by 1, 2, 4, 8.
// - Gate enable: count only while gate low.
package counter_osc_pkg;

    // ------------------------------------------------------------------
    // Bus and register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0b;
    localparam logic [7:0] ADDR_PERIPHERAL_IRQ_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_COUNTER_LOW_BYTE = 8'h0e;
    localparam logic [7:0] ADDR_COUNTER_HIGH_BYTE = 8'h0f;
    localparam logic [7:0] ADDR_COUNTER_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_PERIPHERAL_IRQ_ENABLES = 8'h8c;
    localparam logic [7:0] ADDR_PIN_DIRECTION = 8'h85;
    localparam logic [7:0] ADDR_PIN_LEVEL = 8'h05;

    // ------------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------------
    localparam int INT_GLOBAL_BIT = 7;
    localparam int INT_PERIPHERAL_BIT = 6;
    localparam int FLAG_OVERFLOW_BIT = 0;
    localparam logic [7:0] INTERRUPT_CONTROL_RESET = 8'h00;
    localparam logic [6:0] COUNTER_CONTROL_RESET = 7'h00;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [1:0] PIN_DIRECTION_RESET = 2'h3;
    localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int OSC_RATED_MAX_HZ = 37000;
    localparam int OSC_NOMINAL_HZ = 32000;
    localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
    // Clock samples per cycle of the fastest rated crystal; far above two, so no edge is lost.
    localparam int OSC_SAMPLES_PER_CYCLE = CLK_HZ / OSC_RATED_MAX_HZ;
    localparam int FOSC_DIVIDE = 4;
    localparam logic [1:0] FOSC_DIV_LAST = 2'(FOSC_DIVIDE - 1);

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic gate_enable;
        logic [1:0] prescale_select;
        logic counter_osc_enable;
        logic ext_clock_sync_disable;
        logic clock_source_select;
        logic counter_on;
    } counter_control_s;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;

endpackage

//--- core/counter_osc_sleep_wake.sv
/*
 * Counter block: 16-bit count, prescaler, gate, oscillator pin control,
 * sticky overflow flag with enable, wake and interrupt outputs, register port.
 * Assumes pins are asynchronous to clk and are synchronised here; sleep,
 * sys_clock_internal and the register port come from logic on clk.
 */
`timescale 1ns/1ps
`default_nettype none

module counter_osc_sleep_wake
    import counter_osc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Register port
    input wire reg_req_s req,
    output logic [DATA_W-1:0] rdata,
    // System state
    input wire logic sleep,
    input wire logic sys_clock_internal,
    // Pins
    input wire logic ext_clock_pin,
    input wire logic gate_pin,
    input wire logic osc_input_pin,
    output logic osc_output_pin,
    output logic osc_output_oe,
    input wire logic shared_pin_a,
    input wire logic shared_pin_b,
    output logic pin4_direction,
    output logic pin5_direction,
    // Events
    output logic irq,
    output logic wake,
    output logic isr_request
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        counter_control_s ctl;
        logic [7:0] interrupt_control;
        logic [15:0] count;
        logic overflow_flag;
        logic overflow_irq_enable;
        logic [1:0] pin_dir_sw;
        logic [1:0] fosc_div;
        logic [2:0] presc;
        logic ext_meta;
        logic ext_sync;
        logic osc_meta;
        logic osc_sync;
        logic gate_meta;
        logic gate_sync;
        logic [1:0] pin_meta;
        logic [1:0] pin_sync;
        logic src_prev;
        logic [7:0] rdata;
        logic irq;
        logic wake;
        logic isr;
        logic osc_out;
        logic osc_oe;
        logic [1:0] pin_dir_out;
    } state_s;

    state_s st;
    state_s next_st;

    logic osc_active;
    logic src_level;
    logic in_tick;
    logic sleep_ok;
    logic gate_open;
    logic run;
    logic [2:0] presc_last;
    logic count_tick;
    logic overflow_set;
    logic flag_clear;
    logic [7:0] read_value;

    // ------------------------------------------------------------------
    // Counting path
    // ------------------------------------------------------------------
    always_comb
    begin
        osc_active = st.ctl.counter_osc_enable & sys_clock_internal;
        src_level = osc_active ? st.osc_sync : st.ext_sync;
        in_tick = st.ctl.clock_source_select ? (src_level & ~st.src_prev)
                                             : (st.fosc_div == FOSC_DIV_LAST);
        sleep_ok = ~sleep | (st.ctl.clock_source_select & st.ctl.ext_clock_sync_disable);
        gate_open = ~st.ctl.gate_enable | ~st.gate_sync;
        run = st.ctl.counter_on & gate_open & sleep_ok;
        unique case (st.ctl.prescale_select)
            2'b00: presc_last = 3'h0;
            2'b01: presc_last = 3'h1;
            2'b10: presc_last = 3'h3;
            2'b11: presc_last = 3'h7;
        endcase
        count_tick = run & in_tick & (st.presc == presc_last);
        overflow_set = count_tick & (st.count == COUNT_ALL_ONES);
        flag_clear = req.wr & (req.addr == ADDR_PERIPHERAL_IRQ_FLAGS)
                     & req.wdata[FLAG_OVERFLOW_BIT];
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb
    begin
        read_value = 8'h00;
        unique case (req.addr)
            ADDR_INTERRUPT_CONTROL: read_value = st.interrupt_control;
            ADDR_PERIPHERAL_IRQ_FLAGS: read_value = {7'h00, st.overflow_flag};
            ADDR_COUNTER_LOW_BYTE: read_value = st.count[7:0];
            ADDR_COUNTER_HIGH_BYTE: read_value = st.count[15:8];
            ADDR_COUNTER_CONTROL: read_value = {1'b0, st.ctl};
            ADDR_PERIPHERAL_IRQ_ENABLES: read_value = {7'h00, st.overflow_irq_enable};
            // While the oscillator owns the pins they read as inputs at level zero.
            ADDR_PIN_DIRECTION: read_value = {6'h00, st.pin_dir_out};
            ADDR_PIN_LEVEL: read_value = osc_active ? 8'h00 : {2'h0, st.pin_sync, 4'h0};
            default: read_value = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.ext_meta = ext_clock_pin;
        next_st.ext_sync = st.ext_meta;
        next_st.osc_meta = osc_input_pin;
        next_st.osc_sync = st.osc_meta;
        next_st.gate_meta = gate_pin;
        next_st.gate_sync = st.gate_meta;
        next_st.pin_meta = {shared_pin_b, shared_pin_a};
        next_st.pin_sync = st.pin_meta;
        next_st.src_prev = src_level;
        // The Fosc/4 divider runs free, so the internal rate never depends on writes.
        next_st.fosc_div = 2'(st.fosc_div + 2'h1);
        if (run & in_tick)
        begin
            next_st.presc = (st.presc == presc_last) ? 3'h0 : 3'(st.presc + 3'h1);
        end
        if (count_tick)
        begin
            next_st.count = 16'(st.count + 16'h0001);
        end
        // A bus write beats a concurrent increment; stop the counter before writing.
        if (req.wr)
        begin
            unique case (req.addr)
                ADDR_INTERRUPT_CONTROL: next_st.interrupt_control = req.wdata;
                ADDR_COUNTER_LOW_BYTE: next_st.count[7:0] = req.wdata;
                ADDR_COUNTER_HIGH_BYTE: next_st.count[15:8] = req.wdata;
                ADDR_COUNTER_CONTROL:
                begin
                    next_st.ctl = req.wdata[6:0];
                    next_st.presc = 3'h0;
                end
                ADDR_PERIPHERAL_IRQ_ENABLES: next_st.overflow_irq_enable = req.wdata[0];
                ADDR_PIN_DIRECTION: next_st.pin_dir_sw = req.wdata[1:0];
                default: next_st.interrupt_control = st.interrupt_control;
            endcase
        end
        // Set wins over a clear in the same cycle.
        next_st.overflow_flag = (st.overflow_flag & ~flag_clear) | overflow_set;
        next_st.irq = next_st.overflow_flag & next_st.overflow_irq_enable;
        next_st.wake = next_st.irq & next_st.interrupt_control[INT_PERIPHERAL_BIT];
        next_st.isr = next_st.wake & next_st.interrupt_control[INT_GLOBAL_BIT];
        // The amplifier output is not gated by sleep, so the crystal keeps swinging.
        next_st.osc_oe = next_st.ctl.counter_osc_enable & sys_clock_internal;
        next_st.osc_out = next_st.osc_oe & ~st.osc_sync;
        next_st.pin_dir_out = next_st.osc_oe ? 2'h3 : next_st.pin_dir_sw;
        next_st.rdata = req.rd ? read_value : 8'h00;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            st <= '0;
            st.ctl <= COUNTER_CONTROL_RESET;
            st.interrupt_control <= INTERRUPT_CONTROL_RESET;
            st.count <= COUNT_RESET;
            st.pin_dir_sw <= PIN_DIRECTION_RESET;
            st.pin_dir_out <= PIN_DIRECTION_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign irq = st.irq;
    assign wake = st.wake;
    assign isr_request = st.isr;
    assign osc_output_pin = st.osc_out;
    assign osc_output_oe = st.osc_oe;
    assign pin4_direction = st.pin_dir_out[0];
    assign pin5_direction = st.pin_dir_out[1];

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence seq_rollover;
        count_tick && st.count == COUNT_ALL_ONES;
    endsequence

    sequence seq_flag_seen;
        st.overflow_flag && st.count == 16'h0000;
    endsequence

    AST_ROLLOVER_FLAG: assert property (seq_rollover |=> seq_flag_seen)
        else $error("Rollover did not set the overflow flag");

    AST_FLAG_STICKY: assert property (st.overflow_flag && !flag_clear |=> st.overflow_flag)
        else $error("Overflow flag dropped without a clear");

    AST_OSC_PINS: assert property ($rose(st.osc_oe) |-> st.pin_dir_out == 2'h3)
        else $error("Shared pins not forced to input with oscillator on");

    AST_OSC_STOP: assert property (req.wr && req.addr == ADDR_COUNTER_CONTROL && !req.wdata[3]
                                   |=> !st.osc_oe ##1 !st.osc_out)
        else $error("Oscillator kept running after enable cleared");

    AST_SLEEP_HOLD: assert property (sleep && !(st.ctl.clock_source_select
                                     && st.ctl.ext_clock_sync_disable) && !req.wr
                                     |=> st.count == $past(st.count))
        else $error("Counter advanced in sleep outside asynchronous mode");

    AST_GATE_HOLD: assert property (st.ctl.gate_enable && st.gate_sync && !req.wr
                                    |=> $stable(st.count))
        else $error("Counter advanced while gate pin high");

    AST_FOSC_RATE: assert property (run && !st.ctl.clock_source_select
                                    && st.ctl.prescale_select == 2'b00 && count_tick
                                    |=> !count_tick [*3])
        else $error("Internal count faster than Fosc/4");

    AST_PRESCALE_8: assert property (st.ctl.prescale_select == 2'b11 && count_tick
                                     |=> st.presc == 3'h0)
        else $error("Prescaler not restarted after a tick");

    AST_WAKE_PATH: assert property (st.irq && st.interrupt_control[INT_PERIPHERAL_BIT]
                                    && st.interrupt_control[INT_GLOBAL_BIT]
                                    && $stable(st.irq) |-> st.wake && st.isr)
        else $error("Enabled overflow failed to wake and branch");

    AST_READ_LOW: assert property (req.rd && req.addr == ADDR_COUNTER_LOW_BYTE && !req.wr
                                   |=> rdata == $past(st.count[7:0]))
        else $error("Low byte read mismatch");

endmodule

`default_nettype wire

//--- dv/clock_source_model.sv
/*
 * Behavioural 32 kHz crystal or external count clock, scaled down in period.
 * Assumes the bench clock; the pin stands still at 0 while the source is stopped.
 */
`timescale 1ns/1ps
`default_nettype none

module clock_source_model
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Control
    input wire logic run,
    input wire logic [7:0] half,
    // Pin
    output logic pin = 1'b0
);
    logic [7:0] cnt = 8'h00;

    // A stopped source drives its pin to 0, so no spurious rising edge appears between uses.
    always @(posedge clk)
    begin
        if (!rstn || !run)
        begin
            cnt <= 8'h00;
            pin <= 1'b0;
        end
        else if (cnt == half)
        begin
            cnt <= 8'h00;
            pin <= ~pin;
        end
        else
            cnt <= cnt + 8'h01;
    end
endmodule

`default_nettype wire

//--- dv/counter_osc_sleep_wake_tb.sv
/*
 * Self-checking bench of the counter block with random and corner stimulus.
 * Assumes the package and two clock source models; outputs are sampled at falling edges.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end

module counter_osc_sleep_wake_tb
    import counter_osc_pkg::*;
;
    logic clk = 0, rstn = 0, sleep = 0, sys_int = 0, gate = 0, sh_a = 0, sh_b = 0, pp = 0;
    logic ext_run = 0, xt_run = 0, ext_pin, xt_pin, osc_out, osc_oe, d4, d5, irq, wake, isr;
    logic [7:0] half = 8'h06, rv;
    logic [15:0] cv;
    reg_req_s req = '0;
    logic [DATA_W-1:0] rdata;
    int fail_count = 0, samples_checked = 0, cycles = 0, edges = 0, e0, n;
    logic [7:0] ra [8] = '{8'h0b, 8'h0c, 8'h0e, 8'h0f, 8'h10, 8'h8c, 8'h85, 8'h20};
    logic [7:0] re [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h03, 8'h00};

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------------
    // Source edge counter and hang guard
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        pp <= ext_pin | xt_pin;
        if ((ext_pin | xt_pin) && !pp)
            edges++;
        cycles++;
        if (cycles == 30000)
        begin
            fail_count++;
            stop_test();
        end
    end

    counter_osc_sleep_wake u_dut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
        .sleep(sleep), .sys_clock_internal(sys_int), .ext_clock_pin(ext_pin),
        .gate_pin(gate), .osc_input_pin(xt_pin), .osc_output_pin(osc_out),
        .osc_output_oe(osc_oe), .shared_pin_a(sh_a), .shared_pin_b(sh_b),
        .pin4_direction(d4), .pin5_direction(d5), .irq(irq), .wake(wake), .isr_request(isr));
    clock_source_model u_ext (.clk(clk), .rstn(rstn), .run(ext_run), .half(half), .pin(ext_pin));
    clock_source_model u_xt (.clk(clk), .rstn(rstn), .run(xt_run), .half(half), .pin(xt_pin));

    // ------------------------------------------------------------------
    // Register port tasks and expectations
    // ------------------------------------------------------------------
    // Each task that drives req waits an edge first, so a strobe is never assigned twice in one step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        req <= '0;
        @(negedge clk);
        d = rdata;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d);
        `CHECK($sformatf("reg %h", a), e, d)
    endtask
    task automatic put16(input logic [15:0] v);
        wr(ADDR_COUNTER_HIGH_BYTE, v[15:8]);
        wr(ADDR_COUNTER_LOW_BYTE, v[7:0]);
    endtask
    task automatic get16();
        rd(ADDR_COUNTER_LOW_BYTE, cv[7:0]);
        rd(ADDR_COUNTER_HIGH_BYTE, cv[15:8]);
    endtask
    task automatic inr(input string nm, input int lo, input int hi);
        `CHECK(nm, 1'b1, (int'(cv) >= lo && int'(cv) <= hi))
    endtask
    function automatic int ticks(input int cyc, input int ps);
        return cyc / (FOSC_DIVIDE << ps);
    endfunction
    // Counts a window of source edges; the count lags by the synchroniser, so allow one.
    task automatic burst(input logic osc);
        @(posedge clk);
        e0 = edges;
        half <= 8'(4 + $urandom % 8);
        if (osc) xt_run <= 1'b1; else ext_run <= 1'b1;
        repeat (300) @(posedge clk);
        xt_run <= 1'b0;
        ext_run <= 1'b0;
        repeat (10) @(posedge clk);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        void'($urandom(32'hddb10170));
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        foreach (ra[i]) rdc(ra[i], re[i]);
        rv = 8'($urandom) & 8'hf6;
        wr(ADDR_COUNTER_CONTROL, rv);
        rdc(ADDR_COUNTER_CONTROL, rv & 8'h76);
        n = $urandom;
        put16(16'(n));
        get16();
        `CHECK("count bytes", 16'(n), cv)
        $display("test registers done");
        for (int ps = 0; ps < 4; ps++)
        begin
            n = 64 + $urandom % 64;
            put16(16'h0000);
            wr(ADDR_COUNTER_CONTROL, 8'(ps << 4) | 8'h01);
            repeat (n) @(posedge clk);
            wr(ADDR_COUNTER_CONTROL, 8'h00);
            get16();
            inr("prescaled count", ticks(n, ps) - 1, ticks(n + 4, ps) + 1);
        end
        @(posedge clk);
        gate <= 1'b1;
        put16(16'h0000);
        wr(ADDR_COUNTER_CONTROL, 8'h41);
        repeat (40) @(posedge clk);
        get16();
        `CHECK("gated count", 16'h0000, cv)
        @(posedge clk);
        gate <= 1'b0;
        repeat (40) @(posedge clk);
        wr(ADDR_COUNTER_CONTROL, 8'h00);
        get16();
        inr("open gate count", 8, 14);
        $display("test counting done");
        for (int g = 0; g < 2; g++)
        begin
            wr(ADDR_INTERRUPT_CONTROL, g ? 8'hc0 : 8'h40);
            wr(ADDR_PERIPHERAL_IRQ_ENABLES, 8'h01);
            put16(16'hfff0);
            wr(ADDR_COUNTER_CONTROL, 8'h01);
            for (n = 0; n < 200 && irq !== 1'b1; n++) @(negedge clk);
            `CHECK("overflow time", 1'b1, (n > 55 && n < 75))
            `CHECK("wake", 1'b1, wake)
            `CHECK("isr request", 1'(g), isr)
            wr(ADDR_COUNTER_CONTROL, 8'h00);
            wr(ADDR_PERIPHERAL_IRQ_ENABLES, 8'h00);
            @(negedge clk);
            `CHECK("masked irq", 1'b0, irq | wake)
            rdc(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h01);
            wr(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h01);
            rdc(ADDR_PERIPHERAL_IRQ_FLAGS, 8'h00);
        end
        $display("test overflow done");
        wr(ADDR_PIN_DIRECTION, 8'h00);
        @(negedge clk);
        `CHECK("free directions", 2'b00, {d5, d4})
        @(posedge clk);
        sys_int <= 1'b1;
        sh_a <= 1'b1;
        sh_b <= 1'b1;
        wr(ADDR_COUNTER_CONTROL, 8'h08);
        @(negedge clk);
        `CHECK("osc drive", 1'b1, osc_oe)
        `CHECK("forced directions", 2'b11, {d5, d4})
        rdc(ADDR_PIN_DIRECTION, 8'h03);
        rdc(ADDR_PIN_LEVEL, 8'h00);
        put16(16'h0000);
        wr(ADDR_COUNTER_CONTROL, 8'h0b);
        burst(1'b1);
        wr(ADDR_COUNTER_CONTROL, 8'h08);
        get16();
        inr("crystal count", edges - e0 - 1, edges - e0);
        wr(ADDR_COUNTER_CONTROL, 8'h00);
        @(negedge clk);
        `CHECK("osc stopped", 3'b000, {osc_oe, osc_out, d4})
        rdc(ADDR_PIN_LEVEL, 8'h30);
        @(posedge clk);
        sys_int <= 1'b0;
        wr(ADDR_COUNTER_CONTROL, 8'h08);
        @(negedge clk);
        `CHECK("osc with outer clock", 1'b0, osc_oe)
        $display("test oscillator done");
        put16(16'h0000);
        wr(ADDR_COUNTER_CONTROL, 8'h03);
        sleep <= 1'b1;
        burst(1'b0);
        sleep <= 1'b0;
        get16();
        `CHECK("synced sleep count", 16'h0000, cv)
        wr(ADDR_COUNTER_CONTROL, 8'h07);
        sleep <= 1'b1;
        burst(1'b0);
        sleep <= 1'b0;
        wr(ADDR_COUNTER_CONTROL, 8'h00);
        get16();
        inr("async sleep count", edges - e0 - 1, edges - e0);
        $display("test sleep done");
        stop_test();
    end
endmodule

`default_nettype wire
